// ==== core/aor_pkg.sv ====
/*
 * constants of the offset, slow-rate, swing and trim configuration bank:
 * register indices, writable-bit masks, field positions, reset value and
 * sample-path widths.
 * assumes a byte address of four times the register index on the bus.
 */
package aor_pkg;
	localparam int          NREG     = 13;
	localparam int          SMP_W    = 14;
	localparam int          ACC_W    = 32;
	localparam int          TAU_W    = 4;
	localparam int          PED_W    = 6;
	localparam logic [13:0] MIDCODE  = 14'h2000;
	localparam logic [13:0] SMP_MAX  = 14'h3FFF;
	localparam logic [7:0]  REG_RST  = 8'h00;

	// storage slots
	localparam int S_PERF_A = 0;
	localparam int S_DIG    = 1;
	localparam int S_OFS_EN = 2;
	localparam int S_PED_A  = 3;
	localparam int S_PED_B  = 4;
	localparam int S_LOOP   = 5;
	localparam int S_PERF_B = 6;
	localparam int S_PERF_C = 7;
	localparam int S_PERF_D = 8;
	localparam int S_SLOW_B = 9;
	localparam int S_SLOW_M = 10;
	localparam int S_SWING  = 11;
	localparam int S_SLOW_A = 12;

	// register index per slot; byte address is index times four
	localparam logic [7:0] REG_IDX [NREG] = '{
		8'h02, 8'h42, 8'hE0, 8'hBF, 8'hC1, 8'hCF, 8'hD5,
		8'hD7, 8'hD8, 8'hDB, 8'hEF, 8'hF1, 8'hF2};
	// writable bits per slot; all others store and read zero
	localparam logic [7:0] REG_MASK [NREG] = '{
		8'h40, 8'h08, 8'h20, 8'hFC, 8'hFC, 8'hBC, 8'h81,
		8'h0C, 8'h20, 8'h01, 8'h10, 8'h03, 8'h08};

	localparam int B_DIG_EN = 3;
	localparam int B_OFS_EN = 5;
	localparam int B_HOLD   = 7;
	localparam int B_TAU_LO = 2;
	localparam int B_PED_LO = 2;
	localparam int B_SLOW_B = 0;
	localparam int B_SLOW_M = 4;
	localparam int B_SLOW_A = 3;
	localparam int B_PERF3  = 6;
	localparam int B_PERF4  = 7;
	localparam int B_PERF5  = 0;
	localparam int B_PERF6  = 3;
	localparam int B_PERF7  = 2;
	localparam int B_PERF8  = 5;
	localparam logic [1:0] SWING_ON = 2'h3;

	localparam int         A_IDX_LO   = 2;
	localparam int         A_IDX_HI   = 9;
	localparam int         HTRANS_ACT = 1;
	localparam logic       HRESP_OKAY = 1'b0;
endpackage

// ==== core/aor_ahb_fe.sv ====
/*
 * ahb-lite address-phase capture: holds index, direction and validity of
 * the transfer for its data phase.
 * assumes the slave is always ready, so each data phase lasts one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module aor_ahb_fe
	import aor_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        srst_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic        hready_i,
	output logic             dph_wr_o,
	output logic             dph_ok_o,
	output logic [7:0]       dph_idx_o
);
	logic       take;
	logic       aligned;
	logic       act_q;
	logic       wr_q;
	logic       ok_q;
	logic [7:0] idx_q;

	assign take    = hsel_i & htrans_i[HTRANS_ACT];
	assign aligned = (haddr_i[31:A_IDX_HI+1] == '0) & (haddr_i[A_IDX_LO-1:0] == '0);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			act_q <= 1'b0;
			wr_q  <= 1'b0;
			ok_q  <= 1'b0;
			idx_q <= 8'h00;
		end else if (hready_i) begin
			act_q <= take;
			wr_q  <= hwrite_i;
			ok_q  <= aligned;
			idx_q <= haddr_i[A_IDX_HI:A_IDX_LO];
		end
	end

	assign dph_wr_o  = act_q & wr_q;
	assign dph_ok_o  = act_q & ok_q;
	assign dph_idx_o = idx_q;
endmodule
`default_nettype wire

// ==== core/aor_ofs_loop.sv ====
/*
 * per-channel offset correction loop: leaky integrator of the error
 * against midcode plus pedestal, freeze and bypass.
 * assumes one sample per clock in offset binary.
 */
`timescale 1ns/1ps
`default_nettype none
module aor_ofs_loop
	import aor_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic             run_i,
	input  wire logic             hold_i,
	input  wire logic [TAU_W-1:0] tau_i,
	input  wire logic [PED_W-1:0] ped_i,
	input  wire logic [SMP_W-1:0] smp_i,
	output logic      [SMP_W-1:0] cor_o,
	output logic      [15:0]      est_o
);
	logic signed [ACC_W-1:0] acc_q;
	logic signed [ACC_W-1:0] acc_d;
	logic signed [ACC_W-1:0] est;
	logic signed [15:0]      tgt;
	logic signed [15:0]      err;
	logic signed [16:0]      y;
	logic        [SMP_W-1:0] sat;

	// signed pedestal shifts the settling target
	assign tgt   = $signed({2'b00, MIDCODE}) + $signed({{10{ped_i[PED_W-1]}}, ped_i});
	assign err   = $signed({2'b00, smp_i}) - tgt;
	// time constant is two to the power of the code, in clocks
	assign est   = acc_q >>> tau_i;
	assign acc_d = acc_q + ACC_W'(err) - est;
	assign y     = $signed({3'b000, smp_i}) - est[16:0];
	assign sat   = y[16] ? '0 : (y > $signed({3'b000, SMP_MAX})) ? SMP_MAX : y[SMP_W-1:0];
	assign est_o = est[15:0];

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			acc_q <= '0;
			cor_o <= '0;
		end else begin
			if (!run_i)
				acc_q <= '0;
			else if (!hold_i)
				acc_q <= acc_d;
			cor_o <= run_i ? sat : smp_i;
		end
	end
endmodule
`default_nettype wire

// ==== core/aor_cfg_top.sv ====
/*
 * configuration bank for offset correction, slow-rate mode, lvds swing
 * enable and performance trims, with both channel correction loops.
 * assumes an ahb-lite master with single word transfers; samples arrive
 * one per clock on the core clock.
 */
// How it works
// - pedestal spans minus 32 to plus 31
// - pedestal code read as two's complement
// - loop settles output at midcode plus pedestal
// - each channel has its own pedestal register
// - freeze holds last estimate, still applied
// - time constant from offset control bits 5:2
// - channel b slow mode bit 0, gated
// - channel a slow mode bit 3, gated
// - master slow enable bit 4 gates both
// - swing bits used only when field is 11
// - trim bit placement across four registers
// - all registers clear to zero at reset
// - loop runs only with correction enable set
// - digital enable gates only the correction loops
`timescale 1ns/1ps
`default_nettype none
module aor_cfg_top
	import aor_pkg::*;
(
	input  wire logic             CORE_CLK_I,
	input  wire logic             SRST_I,
	input  wire logic             HSEL_I,
	input  wire logic [31:0]      HADDR_I,
	input  wire logic [1:0]       HTRANS_I,
	input  wire logic             HWRITE_I,
	input  wire logic [2:0]       HSIZE_I,
	input  wire logic [31:0]      HWDATA_I,
	input  wire logic             HREADY_I,
	output logic      [31:0]      HRDATA_O,
	output logic                  HREADYOUT_O,
	output logic                  HRESP_O,
	input  wire logic [SMP_W-1:0] SMP_A_I,
	input  wire logic [SMP_W-1:0] SMP_B_I,
	output logic      [SMP_W-1:0] COR_A_O,
	output logic      [SMP_W-1:0] COR_B_O,
	output logic                  SLOW_RATE_A_O,
	output logic                  SLOW_RATE_B_O,
	output logic                  SWING_CTRL_EN_O,
	output logic      [5:0]       PERF_TRIM_O,
	output logic                  DIG_EN_O
);
	logic             dph_wr;
	logic             dph_ok;
	logic [7:0]       dph_idx;
	logic [NREG-1:0]  hit;
	logic [NREG-1:0]  wr_hit;
	logic [7:0]       regs_q [NREG];
	logic [7:0]       rd_byte;
	logic             dig_en;
	logic             ofs_on;
	logic             run;
	logic             hold;
	logic [TAU_W-1:0] tau;
	logic [PED_W-1:0] ped_a;
	logic [PED_W-1:0] ped_b;
	logic             slow_master;
	logic [15:0]      est_a;
	logic [15:0]      est_b;

	// bus front end

	aor_ahb_fe u_fe (
		.clk_i     (CORE_CLK_I),
		.srst_i    (SRST_I),
		.hsel_i    (HSEL_I),
		.haddr_i   (HADDR_I),
		.htrans_i  (HTRANS_I),
		.hwrite_i  (HWRITE_I),
		.hready_i  (HREADY_I),
		.dph_wr_o  (dph_wr),
		.dph_ok_o  (dph_ok),
		.dph_idx_o (dph_idx)
	);

	// zero-wait slave; hsize is accepted as word, lane 0 carries the byte
	assign HREADYOUT_O = 1'b1;
	assign HRESP_O     = HRESP_OKAY;

	// register storage

	genvar gi;
	generate
		for (gi = 0; gi < NREG; gi++) begin : g_reg
			assign hit[gi]    = dph_ok & (dph_idx == REG_IDX[gi]);
			assign wr_hit[gi] = dph_wr & hit[gi];
			always_ff @(posedge CORE_CLK_I) begin
				if (SRST_I)
					regs_q[gi] <= REG_RST;
				else if (wr_hit[gi])
					regs_q[gi] <= HWDATA_I[7:0] & REG_MASK[gi];
			end
		end
	endgenerate

	// read mux; unmapped or reserved bits read zero
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < NREG; i++) begin
			if (hit[i])
				rd_byte = regs_q[i];
		end
	end

	assign HRDATA_O = {24'h000000, rd_byte};

	// decoded controls

	assign dig_en = regs_q[S_DIG][B_DIG_EN];
	assign ofs_on = regs_q[S_OFS_EN][B_OFS_EN];
	assign run    = dig_en & ofs_on;
	assign hold   = regs_q[S_LOOP][B_HOLD];
	assign tau    = regs_q[S_LOOP][B_TAU_LO +: TAU_W];
	assign ped_a  = regs_q[S_PED_A][B_PED_LO +: PED_W];
	assign ped_b  = regs_q[S_PED_B][B_PED_LO +: PED_W];

	assign DIG_EN_O = dig_en;

	assign slow_master   = regs_q[S_SLOW_M][B_SLOW_M];
	assign SLOW_RATE_A_O = slow_master & regs_q[S_SLOW_A][B_SLOW_A];
	assign SLOW_RATE_B_O = slow_master & regs_q[S_SLOW_B][B_SLOW_B];

	// 01 and 10 leave the swing level bits ignored, like 00
	assign SWING_CTRL_EN_O = (regs_q[S_SWING][1:0] == SWING_ON);

	assign PERF_TRIM_O = {
		regs_q[S_PERF_D][B_PERF8],
		regs_q[S_PERF_C][B_PERF7],
		regs_q[S_PERF_C][B_PERF6],
		regs_q[S_PERF_B][B_PERF5],
		regs_q[S_PERF_B][B_PERF4],
		regs_q[S_PERF_A][B_PERF3]};

	// correction loops, one per channel

	aor_ofs_loop u_loop_a (
		.clk_i  (CORE_CLK_I),
		.srst_i (SRST_I),
		.run_i  (run),
		.hold_i (hold),
		.tau_i  (tau),
		.ped_i  (ped_a),
		.smp_i  (SMP_A_I),
		.cor_o  (COR_A_O),
		.est_o  (est_a)
	);

	aor_ofs_loop u_loop_b (
		.clk_i  (CORE_CLK_I),
		.srst_i (SRST_I),
		.run_i  (run),
		.hold_i (hold),
		.tau_i  (tau),
		.ped_i  (ped_b),
		.smp_i  (SMP_B_I),
		.cor_o  (COR_B_O),
		.est_o  (est_b)
	);

	// checks

	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (SRST_I);

	AST_RESET_CLEAR: assert property (
		$past(SRST_I) |-> (PERF_TRIM_O == 6'h00) && !SLOW_RATE_A_O
			&& !SLOW_RATE_B_O && !SWING_CTRL_EN_O && !DIG_EN_O
			&& (COR_A_O == 14'h0000))
		else $error("bank not clear after reset");

	AST_SLOW_GATE: assert property (
		!regs_q[S_SLOW_M][B_SLOW_M] |-> !SLOW_RATE_A_O && !SLOW_RATE_B_O)
		else $error("slow mode on without master enable");

	AST_SLOW_B_WRITE: assert property (
		wr_hit[S_SLOW_B] && regs_q[S_SLOW_M][B_SLOW_M]
			&& !wr_hit[S_SLOW_M]
		|=> SLOW_RATE_B_O == $past(HWDATA_I[B_SLOW_B]))
		else $error("channel b slow mode does not follow its bit");

	AST_SLOW_A_WRITE: assert property (
		wr_hit[S_SLOW_A] && regs_q[S_SLOW_M][B_SLOW_M]
			&& !wr_hit[S_SLOW_M]
		|=> SLOW_RATE_A_O == $past(HWDATA_I[B_SLOW_A]))
		else $error("channel a slow mode does not follow its bit");

	AST_SWING_FIELD: assert property (
		wr_hit[S_SWING] |=> SWING_CTRL_EN_O == ($past(HWDATA_I[1:0]) == 2'h3))
		else $error("swing enable does not match field 11");

	AST_TRIM_PLACE: assert property (
		wr_hit[S_PERF_B]
		|=> PERF_TRIM_O[1] == $past(HWDATA_I[7]) && PERF_TRIM_O[2] == $past(HWDATA_I[0]))
		else $error("trim 4 or 5 misplaced");

	AST_WRITE_HOLD: assert property (
		wr_hit[S_LOOP] ##1 !wr_hit[S_LOOP] [*2]
		|-> regs_q[S_LOOP] == ($past(HWDATA_I[7:0], 2) & REG_MASK[S_LOOP]))
		else $error("loop control not held after write");

	AST_FREEZE_HOLDS: assert property (
		run && hold && !$past(wr_hit[S_LOOP]) && $past(run && hold)
		|-> est_a == $past(est_a) && est_b == $past(est_b))
		else $error("estimate moved while frozen");

	AST_BYPASS: assert property (
		!run |=> COR_A_O == $past(SMP_A_I) && COR_B_O == $past(SMP_B_I))
		else $error("samples altered with correction off");

	AST_DIG_GATE: assert property (
		!regs_q[S_DIG][B_DIG_EN] ##1 1'b1 |-> est_a == 16'h0000)
		else $error("estimate kept with digital functions off");

	AST_READBACK: assert property (
		dph_ok && !dph_wr && hit[S_LOOP]
		|-> HRDATA_O == {24'h000000, regs_q[S_LOOP]} && (HRDATA_O[1:0] == 2'h0))
		else $error("readback differs from stored value");

	AST_TARGET_B: assert property (
		run && !hold && (tau == 4'h0) ##1 run && !hold && $stable(SMP_B_I)
			&& $stable(ped_b) && (tau == 4'h0)
		|=> COR_B_O == 14'(MIDCODE + $past({{8{ped_b[PED_W-1]}}, ped_b})))
		else $error("channel b not at midcode plus pedestal");

	AST_TARGET_A: assert property (
		run && !hold && (tau == 4'h0) ##1 run && !hold && $stable(SMP_A_I)
			&& $stable(ped_a) && (tau == 4'h0)
		|=> COR_A_O == 14'(MIDCODE + $past({{8{ped_a[PED_W-1]}}, ped_a})))
		else $error("channel a not at midcode plus pedestal");

	AST_FREEZE_OUT: assert property (
		run && hold && $past(run && hold) && !$past(wr_hit[S_LOOP])
			&& $stable(SMP_A_I)
		|=> $stable(COR_A_O))
		else $error("frozen estimate not applied every cycle");

	AST_FREEZE_OUT_B: assert property (
		run && hold && $past(run && hold) && !$past(wr_hit[S_LOOP])
			&& $stable(SMP_B_I)
		|=> $stable(COR_B_O))
		else $error("frozen estimate not applied on channel b");

	AST_LOOP_CLEAR: assert property (
		!run |=> est_a == 16'h0000 && est_b == 16'h0000)
		else $error("estimate kept with correction off");

	AST_RUN_OFF: assert property (
		wr_hit[S_OFS_EN] && !HWDATA_I[B_OFS_EN] |=> !run)
		else $error("loop still runs after correction disable");

	AST_RUN_ON: assert property (
		wr_hit[S_OFS_EN] && HWDATA_I[B_OFS_EN] && regs_q[S_DIG][B_DIG_EN] |=> run)
		else $error("loop idle after correction enable");

	AST_DIG_OFF: assert property (
		wr_hit[S_DIG] && !HWDATA_I[B_DIG_EN] |=> !run && !DIG_EN_O)
		else $error("digital functions left on after disable");

	AST_DIG_WRITE: assert property (
		wr_hit[S_DIG] |=> DIG_EN_O == $past(HWDATA_I[B_DIG_EN]))
		else $error("digital enable does not follow its bit");

	AST_RESET_OUT: assert property (
		$past(SRST_I) |-> est_a == 16'h0000 && est_b == 16'h0000
			&& COR_B_O == 14'h0000 && HRDATA_O == 32'h00000000)
		else $error("loop or read data not clear after reset");

	// field placement and write behaviour

	AST_TAU_FIELD: assert property (
		wr_hit[S_LOOP]
		|=> tau == $past(HWDATA_I[5:2]) && hold == $past(HWDATA_I[B_HOLD]))
		else $error("time constant or freeze field misplaced");

	AST_PED_A_WRITE: assert property (
		wr_hit[S_PED_A]
		|=> ped_a == $past(HWDATA_I[7:2]) && ped_b == $past(ped_b))
		else $error("channel a pedestal write disturbed channel b");

	AST_PED_B_WRITE: assert property (
		wr_hit[S_PED_B]
		|=> ped_b == $past(HWDATA_I[7:2]) && ped_a == $past(ped_a))
		else $error("channel b pedestal write disturbed channel a");

	AST_WRITE_IDLE: assert property (
		!dph_wr |=> regs_q[S_PED_A] == $past(regs_q[S_PED_A])
			&& regs_q[S_SWING] == $past(regs_q[S_SWING]))
		else $error("register changed without a write");

	AST_SLOW_MASTER_OFF: assert property (
		wr_hit[S_SLOW_M] && !HWDATA_I[B_SLOW_M]
		|=> !SLOW_RATE_A_O && !SLOW_RATE_B_O)
		else $error("slow mode left on after master disable");

	AST_SLOW_MASTER_ON: assert property (
		wr_hit[S_SLOW_M] && HWDATA_I[B_SLOW_M]
		|=> SLOW_RATE_A_O == $past(regs_q[S_SLOW_A][B_SLOW_A])
			&& SLOW_RATE_B_O == $past(regs_q[S_SLOW_B][B_SLOW_B]))
		else $error("channel bits ignored with master enable set");

	AST_SWING_PART: assert property (
		wr_hit[S_SWING] && (HWDATA_I[1:0] != SWING_ON) |=> !SWING_CTRL_EN_O)
		else $error("swing control on with partial field");

	AST_SWING_ON: assert property (
		wr_hit[S_SWING] && (HWDATA_I[1:0] == SWING_ON) |=> SWING_CTRL_EN_O)
		else $error("swing control off with field 11");

	AST_TRIM_A: assert property (
		wr_hit[S_PERF_A] |=> PERF_TRIM_O[0] == $past(HWDATA_I[6]))
		else $error("trim 3 misplaced");

	AST_TRIM_C: assert property (
		wr_hit[S_PERF_C]
		|=> PERF_TRIM_O[3] == $past(HWDATA_I[3]) && PERF_TRIM_O[4] == $past(HWDATA_I[2]))
		else $error("trim 6 or 7 misplaced");

	AST_TRIM_D: assert property (
		wr_hit[S_PERF_D] |=> PERF_TRIM_O[5] == $past(HWDATA_I[5]))
		else $error("trim 8 misplaced");

	AST_TRIM_RESERVED: assert property (
		dph_ok && !dph_wr && hit[S_PERF_B] |-> HRDATA_O[6:1] == 6'h00)
		else $error("reserved trim bits read nonzero");

	CVR_FREEZE: cover property (run && hold ##1 run && hold);
	CVR_SLOW_A: cover property (SLOW_RATE_A_O);
	CVR_SWING:  cover property (SWING_CTRL_EN_O);
	CVR_RUN:    cover property (run && (COR_A_O != SMP_A_I));
endmodule
`default_nettype wire

// ==== testbench/aor_host.sv ====
/*
 * ahb-lite host model: single word transfers to the configuration bank.
 * assumes one slave whose hreadyout is the bus hready.
 */
`timescale 1ns/1ps
`default_nettype none
module aor_host (
	input  wire logic        clk_i,
	input  wire logic        hready_i,
	input  wire logic [31:0] hrdata_i,
	output logic             hsel_o,
	output logic      [31:0] haddr_o,
	output logic      [1:0]  htrans_o,
	output logic             hwrite_o,
	output logic      [2:0]  hsize_o,
	output logic      [31:0] hwdata_o
);
	initial begin
		hsel_o   = 1'b0;
		haddr_o  = 32'h0;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hsize_o  = 3'h2;
		hwdata_o = 32'h0;
	end

	// call right after a rising edge; released lines show inverted values
	task automatic xfer(input logic [31:0] addr, input logic wr, input logic [7:0] wd,
		output logic [31:0] rd);
		hsel_o   <= 1'b1;
		haddr_o  <= addr;
		htrans_o <= 2'h2;
		hwrite_o <= wr;
		@(posedge clk_i);
		while (hready_i !== 1'b1) @(posedge clk_i);
		htrans_o <= 2'h0;
		haddr_o  <= ~addr;
		hwdata_o <= {24'h0, wd};
		@(posedge clk_i);
		while (hready_i !== 1'b1) @(posedge clk_i);
		rd = hrdata_i;
		hwdata_o <= ~{24'h0, wd};
	endtask
endmodule
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
 * self-checking bench for the configuration bank: register map, outputs,
 * resets and both correction loops against a register-array model.
 * assumes the host model aor_host.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import aor_pkg::*;
	logic             clk = 1'b0;
	logic             srst = 1'b1;
	logic [SMP_W-1:0] smp_a = MIDCODE;
	logic [SMP_W-1:0] smp_b = MIDCODE;
	wire              hsel, hwrite, hready, hresp, sra, srb, swg, dig;
	wire [31:0]       haddr, hwdata, hrdata;
	wire [1:0]        htrans;
	wire [2:0]        hsize;
	wire [SMP_W-1:0]  cor_a, cor_b;
	wire [5:0]        perf;
	logic [7:0]       mdl [NREG];
	logic [31:0]      rd;
	int               n_errors = 0;
	int               total_checks = 0;

	aor_host i_host (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
		.haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize),
		.hwdata_o(hwdata));
	aor_cfg_top i_dut (.CORE_CLK_I(clk), .SRST_I(srst), .HSEL_I(hsel), .HADDR_I(haddr),
		.HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
		.HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
		.SMP_A_I(smp_a), .SMP_B_I(smp_b), .COR_A_O(cor_a), .COR_B_O(cor_b),
		.SLOW_RATE_A_O(sra), .SLOW_RATE_B_O(srb), .SWING_CTRL_EN_O(swg),
		.PERF_TRIM_O(perf), .DIG_EN_O(dig));

	initial forever #2.5 clk = ~clk;

	task automatic conclude();
		if (n_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one register access; reads are compared with the model
	task automatic acc(input int s, input logic wr_en, input logic [7:0] v);
		logic [7:0] w;
		w = v & REG_MASK[s];
		if (s == S_SWING) w = {6'h0, {2{v[0]}}};
		i_host.xfer({22'h0, REG_IDX[s], 2'b00}, wr_en, w, rd);
		chk({30'h0, hready, hresp}, 32'h0000_0002);
		if (wr_en) mdl[s] = w;
		else chk(rd, {24'h0, mdl[s]});
	endtask

	task automatic chk_out();
		logic [9:0] e;
		@(posedge clk);
		e = {mdl[S_PERF_D][5], mdl[S_PERF_C][2], mdl[S_PERF_C][3], mdl[S_PERF_B][0],
			mdl[S_PERF_B][7], mdl[S_PERF_A][6], mdl[S_DIG][3], mdl[S_SWING][1:0] == 2'b11,
			mdl[S_SLOW_M][4] & mdl[S_SLOW_A][3], mdl[S_SLOW_M][4] & mdl[S_SLOW_B][0]};
		chk({22'h0, perf, dig, swg, sra, srb}, {22'h0, e});
	endtask

	task automatic rst_chk();
		srst <= 1'b1;
		mdl = '{default: 8'h00};
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		for (int s = 0; s < NREG; s++) acc(s, 1'b0, 8'h00);
		chk_out();
	endtask

	task automatic chk_cor(input int wt, input logic [SMP_W-1:0] ea,
		input logic [SMP_W-1:0] eb);
		repeat (wt) @(posedge clk);
		chk({18'h0, cor_a}, {18'h0, ea});
		chk({18'h0, cor_b}, {18'h0, eb});
	endtask

	initial begin
		#100000;
		n_errors++;
		conclude();
	end

	initial begin
		void'($urandom(32'hCC2F3711));
		rst_chk();
		for (int n = 0; n < 4; n++) begin
			// master slow enable is written first in every pass
			for (int k = 0; k < NREG; k++) begin
				acc((k + S_SLOW_M) % NREG, 1'b1, 8'($urandom));
				chk_out();
			end
			for (int k = 0; k < NREG; k++) acc(k, 1'b0, 8'h00);
		end
		// unmapped and misaligned places read zero
		i_host.xfer(32'h0000_000C, 1'b1, 8'hFF, rd);
		i_host.xfer(32'h0000_000C, 1'b0, 8'h00, rd);
		chk(rd, 32'h0);
		i_host.xfer({22'h0, REG_IDX[S_PERF_A], 2'b01}, 1'b0, 8'h00, rd);
		chk(rd, 32'h0);
		rst_chk();
		smp_a <= MIDCODE + 14'($urandom_range(900));
		smp_b <= MIDCODE - 14'($urandom_range(900));
		acc(S_DIG, 1'b1, 8'h08);
		acc(S_OFS_EN, 1'b1, 8'h20);
		acc(S_PED_A, 1'b1, 8'h7C);
		acc(S_PED_B, 1'b1, 8'h80);
		chk_cor(8, MIDCODE + 14'd31, MIDCODE - 14'd32);
		acc(S_PED_B, 1'b1, 8'hFC);
		chk_cor(8, MIDCODE + 14'd31, MIDCODE - 14'd1);
		acc(S_LOOP, 1'b1, 8'h80);
		smp_a <= smp_a + 14'd5;
		smp_b <= smp_b + 14'd7;
		chk_cor(4, MIDCODE + 14'd36, MIDCODE + 14'd6);
		acc(S_DIG, 1'b1, 8'h00);
		chk_cor(3, smp_a, smp_b);
		acc(S_DIG, 1'b1, 8'h08);
		acc(S_OFS_EN, 1'b1, 8'h00);
		chk_cor(3, smp_a, smp_b);
		// leaky loop with a two-clock time constant still settles on target
		acc(S_LOOP, 1'b1, 8'h04);
		acc(S_OFS_EN, 1'b1, 8'h20);
		chk_cor(40, MIDCODE + 14'd31, MIDCODE - 14'd1);
		acc(S_PERF_A, 1'b1, 8'hFF);
		acc(S_PERF_B, 1'b1, 8'hFF);
		acc(S_PERF_C, 1'b1, 8'hFF);
		acc(S_PERF_D, 1'b1, 8'hFF);
		chk_out();
		chk({26'h0, perf}, 32'h0000_003F);
		conclude();
	end
endmodule
`default_nettype wire
